//--- hdl/sicr_consts.svh
// Purpose: offsets, field positions, reset values and bus codes of the integration register bank
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   definitions only
`ifndef SICR_CONSTS_SVH
`define SICR_CONSTS_SVH

// register indices (byte address = index * 4)
`define SICR_IDX_CTRL      6'h00
`define SICR_IDX_CAUSE     6'h01
`define SICR_IDX_SCRATCH0  6'h02
`define SICR_IDX_SCRATCH3  6'h05
`define SICR_IDX_ID_UPPER  6'h06
`define SICR_IDX_ID_LOWER  6'h07
`define SICR_IDX_IRQ_STAT  6'h10
`define SICR_IDX_IRQ_MASK  6'h11

// control field positions
`define SICR_CTRL_TRIG_BIT   4
`define SICR_CTRL_STOP_LOCK  3
`define SICR_CTRL_WAIT_LOCK  1
// bits software may store in the control register (reserved and trigger excluded)
`define SICR_CTRL_WR_MASK    16'hFA2F
`define SICR_CTRL_RESET      16'h0000

// reset cause bit positions and values
`define SICR_CAUSE_POR       16'h0004
`define SICR_CAUSE_PIN       16'h0008
`define SICR_CAUSE_WDOG      16'h0010
`define SICR_CAUSE_SW        16'h0020
`define SICR_CAUSE_MASK      16'h003C
`define SICR_CAUSE_WDOG_BIT  4

`define SICR_SCRATCH_RESET   16'h0000
`define SICR_IRQ_RESET       3'h0

// axi4-lite response codes
`define SICR_RESP_OKAY       2'h0
`define SICR_RESP_SLVERR     2'h2

`endif

//--- hdl/sicr_pkg.sv
// Purpose: types shared by the integration register bank
// Assumes: constants live in sicr_consts.svh
// Notes:   control word layout matches the register bit order
package sicr_pkg;

	// control register layout, msb first
	typedef struct packed {
		logic [3:0] timer_stop_clock_en;   // timer3..timer0
		logic       serial_stop_clock_en;
		logic       rsvd10;
		logic       timer3_input_select;
		logic [2:0] rsvd8_6;
		logic       debug_clock_always_on;
		logic       software_reset_trigger;
		logic [1:0] stop_disable;          // [1] lock, [0] disable
		logic [1:0] wait_disable;          // [1] lock, [0] disable
	} sicr_ctrl_type;

	// interrupt event set
	typedef struct packed {
		logic lock_write;    // write to a locked field
		logic wait_blocked;  // wait instruction refused
		logic stop_blocked;  // stop instruction refused
	} sicr_evt_type;

endpackage

//--- hdl/sicr_top.sv
// Purpose: system integration control register bank behind an axi4-lite slave
// Assumes: aclk 40 MHz; por_n async power-on reset; aresetn sync bus reset
// Notes:   one write and one read outstanding; 16-bit registers in low half of each word
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "sicr_consts.svh"

module sicr_top #(
	parameter logic [15:0] CHIP_ID_UPPER = 16'h0A5C, // arbitrary value
	parameter logic [15:0] CHIP_ID_LOWER = 16'h3C69, // arbitrary value
	parameter int          NUM_TIMERS    = 4
) (
	// clock and resets
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    por_n,
	// axi4-lite write address and data
	input  wire logic [7:0]              s_axil_awaddr,
	input  wire logic                    s_axil_awvalid,
	output logic                         s_axil_awready,
	input  wire logic [31:0]             s_axil_wdata,
	input  wire logic [3:0]              s_axil_wstrb,
	input  wire logic                    s_axil_wvalid,
	output logic                         s_axil_wready,
	// axi4-lite write response
	output logic [1:0]                   s_axil_bresp,
	output logic                         s_axil_bvalid,
	input  wire logic                    s_axil_bready,
	// axi4-lite read
	input  wire logic [7:0]              s_axil_araddr,
	input  wire logic                    s_axil_arvalid,
	output logic                         s_axil_arready,
	output logic [31:0]                  s_axil_rdata,
	output logic [1:0]                   s_axil_rresp,
	output logic                         s_axil_rvalid,
	input  wire logic                    s_axil_rready,
	// reset sources
	input  wire logic                    reset_pin_n,
	input  wire logic                    watchdog_reset,
	output logic                         software_reset_req,
	output logic                         use_watchdog_vector,
	// power mode and core
	input  wire logic                    stop_mode,
	input  wire logic                    stop_instr,
	input  wire logic                    wait_instr,
	output logic                         stop_entry,
	output logic                         wait_entry,
	input  wire logic                    core_tap_enabled,
	output logic                         debug_clock_en,
	// peripheral clocks and timer 3 input
	output logic [NUM_TIMERS-1:0]        timer_clock_en,
	output logic                         serial_clock_en,
	input  wire logic                    pwm_reload_sync,
	input  wire logic                    routed_pin_in,
	output logic                         timer3_input,
	// interrupt
	output logic                         irq
);

	// state
	sicr_pkg::sicr_ctrl_type ctrl_q;
	logic [15:0]             cause_q;
	logic [15:0]             scratch_q [4];
	logic [2:0]              irq_stat_q;
	logic [2:0]              irq_mask_q;
	logic                    pin_meta_q, pin_rst_q;
	logic                    route_meta_q, route_q;
	logic                    sw_rst_q;
	logic                    aw_got_q, w_got_q;
	logic [5:0]              aw_idx_q;
	logic [31:0]             w_data_q;
	logic [3:0]              w_strb_q;
	logic [5:0]              rd_idx_q;

	// reset pin and routed pin synchronised, watchdog used as is; pin is active low at the package
	always_ff @(posedge aclk or negedge por_n)
	begin
		if (!por_n)
		begin
			pin_meta_q   <= 1'b0;
			pin_rst_q    <= 1'b0;
			route_meta_q <= 1'b0;
			route_q      <= 1'b0;
		end
		else
		begin
			pin_meta_q   <= ~reset_pin_n;
			pin_rst_q    <= pin_meta_q;
			route_meta_q <= routed_pin_in;
			route_q      <= route_meta_q;
		end
	end

	// system reset: pin, watchdog, trigger or bus reset; power-on is separate
	wire sys_rst = !aresetn || pin_rst_q || watchdog_reset || sw_rst_q;

	// bus handshakes
	wire aw_fire = s_axil_awvalid && s_axil_awready;
	wire w_fire  = s_axil_wvalid && s_axil_wready;
	wire b_fire  = s_axil_bvalid && s_axil_bready;
	wire ar_fire = s_axil_arvalid && s_axil_arready;
	wire r_fire  = s_axil_rvalid && s_axil_rready;
	wire wr_go   = aw_got_q && w_got_q && !s_axil_bvalid;

	// write decode; only the low two byte lanes reach the 16-bit registers
	wire [15:0] lane_mask  = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [15:0] wr_word    = w_data_q[15:0];
	wire        wr_ctrl    = wr_go && (aw_idx_q == `SICR_IDX_CTRL);
	wire        wr_scratch = wr_go && (aw_idx_q >= `SICR_IDX_SCRATCH0)
		&& (aw_idx_q <= `SICR_IDX_SCRATCH3);
	wire [1:0]  scr_sel    = 2'(aw_idx_q - `SICR_IDX_SCRATCH0);
	wire        wr_istat   = wr_go && (aw_idx_q == `SICR_IDX_IRQ_STAT);
	wire        wr_imask   = wr_go && (aw_idx_q == `SICR_IDX_IRQ_MASK);
	wire        wr_known   = (aw_idx_q <= `SICR_IDX_ID_LOWER)
		|| (aw_idx_q == `SICR_IDX_IRQ_STAT) || (aw_idx_q == `SICR_IDX_IRQ_MASK);

	// control merge: reserved bits and the trigger never stored
	wire [15:0] ctrl_mix   = (ctrl_q & ~lane_mask) | (wr_word & lane_mask);
	wire [15:0] ctrl_keep  = ctrl_mix & `SICR_CTRL_WR_MASK;
	wire        stop_lock  = ctrl_q[`SICR_CTRL_STOP_LOCK];
	wire        wait_lock  = ctrl_q[`SICR_CTRL_WAIT_LOCK];
	sicr_pkg::sicr_ctrl_type ctrl_d;
	always_comb
	begin
		ctrl_d = sicr_pkg::sicr_ctrl_type'(ctrl_keep);
		if (stop_lock)
			ctrl_d.stop_disable = ctrl_q.stop_disable;
		if (wait_lock)
			ctrl_d.wait_disable = ctrl_q.wait_disable;
	end
	wire sw_trigger = wr_ctrl && w_strb_q[0] && wr_word[`SICR_CTRL_TRIG_BIT];

	// control register: cleared by every reset, locks fall only there
	always_ff @(posedge aclk or negedge por_n)
	begin
		if (!por_n)
			ctrl_q <= sicr_pkg::sicr_ctrl_type'(`SICR_CTRL_RESET);
		else if (sys_rst)
			ctrl_q <= sicr_pkg::sicr_ctrl_type'(`SICR_CTRL_RESET);
		else if (wr_ctrl)
			ctrl_q <= ctrl_d;
	end

	// trigger pulse; it resets the part one cycle after the write lands
	always_ff @(posedge aclk or negedge por_n)
	begin
		if (!por_n)
			sw_rst_q <= 1'b0;
		else
			sw_rst_q <= sw_trigger && !sys_rst;
	end

	// cause register: power-on sets it async, then levels refresh it by rank
	always_ff @(posedge aclk or negedge por_n)
	begin
		if (!por_n)
			cause_q <= `SICR_CAUSE_POR;
		else if (pin_rst_q)
			cause_q <= `SICR_CAUSE_PIN;
		else if (watchdog_reset)
			cause_q <= `SICR_CAUSE_WDOG;
		else if (sw_rst_q)
			cause_q <= `SICR_CAUSE_SW;
	end

	// scratch words survive every reset but power-on
	always_ff @(posedge aclk or negedge por_n)
	begin
		if (!por_n)
			for (int i = 0; i < 4; i++)
				scratch_q[i] <= `SICR_SCRATCH_RESET;
		else if (wr_scratch)
			scratch_q[scr_sel] <= (scratch_q[scr_sel] & ~lane_mask) | (wr_word & lane_mask);
	end

	// interrupt events; a new event beats a write-one clear
	sicr_pkg::sicr_evt_type evt;
	assign evt.stop_blocked = stop_instr && ctrl_q.stop_disable[0];
	assign evt.wait_blocked = wait_instr && ctrl_q.wait_disable[0];
	assign evt.lock_write   = wr_ctrl && w_strb_q[0] && (stop_lock || wait_lock);
	wire [2:0] istat_clr    = wr_istat && w_strb_q[0] ? wr_word[2:0] : 3'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !por_n)
		begin
			irq_stat_q <= `SICR_IRQ_RESET;
			irq_mask_q <= `SICR_IRQ_RESET;
		end
		else
		begin
			irq_stat_q <= (irq_stat_q & ~istat_clr) | evt;
			if (wr_imask && w_strb_q[0])
				irq_mask_q <= wr_word[2:0];
		end
	end

	// read mux; reserved bits and unknown words read zero
	wire [5:0] ar_idx = s_axil_araddr[7:2];
	wire       rd_scr = (ar_idx >= `SICR_IDX_SCRATCH0) && (ar_idx <= `SICR_IDX_SCRATCH3);
	wire [1:0] rd_sel = 2'(ar_idx - `SICR_IDX_SCRATCH0);
	logic [15:0] rd_word;
	logic        rd_ok;
	always_comb
	begin
		rd_ok   = 1'b1;
		rd_word = 16'h0000;
		if (rd_scr)
			rd_word = scratch_q[rd_sel];
		else if (ar_idx == `SICR_IDX_CTRL)
			rd_word = 16'(ctrl_q) & `SICR_CTRL_WR_MASK;
		else if (ar_idx == `SICR_IDX_CAUSE)
			rd_word = cause_q & `SICR_CAUSE_MASK;
		else if (ar_idx == `SICR_IDX_ID_UPPER)
			rd_word = CHIP_ID_UPPER;
		else if (ar_idx == `SICR_IDX_ID_LOWER)
			rd_word = CHIP_ID_LOWER;
		else if (ar_idx == `SICR_IDX_IRQ_STAT)
			rd_word = {13'h0000, irq_stat_q};
		else if (ar_idx == `SICR_IDX_IRQ_MASK)
			rd_word = {13'h0000, irq_mask_q};
		else
			rd_ok = 1'b0;
	end

	// write channels: address and data taken in any order, answer follows both
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !por_n)
		begin
			s_axil_awready <= 1'b1;
			s_axil_wready  <= 1'b1;
			aw_got_q       <= 1'b0;
			w_got_q        <= 1'b0;
			aw_idx_q       <= 6'h00;
			w_data_q       <= 32'h0000_0000;
			w_strb_q       <= 4'h0;
			s_axil_bvalid  <= 1'b0;
			s_axil_bresp   <= `SICR_RESP_OKAY;
		end
		else
		begin
			if (aw_fire)
			begin
				aw_got_q       <= 1'b1;
				aw_idx_q       <= s_axil_awaddr[7:2];
				s_axil_awready <= 1'b0;
			end
			if (w_fire)
			begin
				w_got_q       <= 1'b1;
				w_data_q      <= s_axil_wdata;
				w_strb_q      <= s_axil_wstrb;
				s_axil_wready <= 1'b0;
			end
			if (wr_go)
			begin
				aw_got_q      <= 1'b0;
				w_got_q       <= 1'b0;
				s_axil_bvalid <= 1'b1;
				s_axil_bresp  <= wr_known ? `SICR_RESP_OKAY : `SICR_RESP_SLVERR;
			end
			if (b_fire)
			begin
				s_axil_bvalid  <= 1'b0;
				s_axil_awready <= 1'b1;
				s_axil_wready  <= 1'b1;
			end
		end
	end

	// read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !por_n)
		begin
			s_axil_arready <= 1'b1;
			s_axil_rvalid  <= 1'b0;
			s_axil_rdata   <= 32'h0000_0000;
			s_axil_rresp   <= `SICR_RESP_OKAY;
			rd_idx_q       <= 6'h00;
		end
		else if (ar_fire)
		begin
			s_axil_arready <= 1'b0;
			s_axil_rvalid  <= 1'b1;
			s_axil_rdata   <= {16'h0000, rd_word};
			s_axil_rresp   <= rd_ok ? `SICR_RESP_OKAY : `SICR_RESP_SLVERR;
			rd_idx_q       <= ar_idx;
		end
		else if (r_fire)
		begin
			s_axil_rvalid  <= 1'b0;
			s_axil_arready <= 1'b1;
		end
	end

	// clock enables in stop mode, per timer channel
	for (genvar t = 0; t < NUM_TIMERS; t++)
	begin : g_timer_clk
		always_ff @(posedge aclk)
		begin
			if (!por_n)
				timer_clock_en[t] <= 1'b1;
			else
				timer_clock_en[t] <= !stop_mode || ctrl_q.timer_stop_clock_en[t];
		end
	end

	// remaining outputs, all registered; one cycle of latency is accepted for a clean edge
	always_ff @(posedge aclk)
	begin
		if (!por_n)
		begin
			serial_clock_en     <= 1'b1;
			timer3_input        <= 1'b0;
			debug_clock_en      <= 1'b0;
			stop_entry          <= 1'b0;
			wait_entry          <= 1'b0;
			use_watchdog_vector <= 1'b0;
			software_reset_req  <= 1'b0;
			irq                 <= 1'b0;
		end
		else
		begin
			serial_clock_en     <= !stop_mode || ctrl_q.serial_stop_clock_en;
			timer3_input        <= ctrl_q.timer3_input_select ? route_q : pwm_reload_sync;
			debug_clock_en      <= ctrl_q.debug_clock_always_on || core_tap_enabled;
			stop_entry          <= stop_instr && !ctrl_q.stop_disable[0];
			wait_entry          <= wait_instr && !ctrl_q.wait_disable[0];
			use_watchdog_vector <= cause_q[`SICR_CAUSE_WDOG_BIT];
			software_reset_req  <= sw_rst_q;
			irq                 <= |(irq_stat_q & irq_mask_q);
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !por_n);

	property p_timer_stop;
		!stop_mode ##1 (stop_mode && ctrl_q.timer_stop_clock_en == 4'h0 && !sys_rst)
			|=> timer_clock_en == 4'h0;
	endproperty
	a_timer_stop: assert property (p_timer_stop) else $error("timer clock runs in stop");

	property p_serial_stop;
		stop_mode && ctrl_q.serial_stop_clock_en |=> serial_clock_en;
	endproperty
	a_serial_stop: assert property (p_serial_stop) else $error("serial clock gated");

	property p_ctrl_rsvd;
		s_axil_rvalid && rd_idx_q == `SICR_IDX_CTRL |-> (s_axil_rdata & 32'h0000_05D0) == 0;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bit read one");

	property p_stop_lock;
		stop_lock && !sys_rst |=> $stable(ctrl_q.stop_disable);
	endproperty
	a_stop_lock: assert property (p_stop_lock) else $error("locked stop field changed");

	property p_sw_reset;
		sw_trigger && !sys_rst ##1 !pin_rst_q && !watchdog_reset
			|-> sw_rst_q ##1 (software_reset_req && cause_q == `SICR_CAUSE_SW);
	endproperty
	a_sw_reset: assert property (p_sw_reset) else $error("software reset not started");

	property p_onehot;
		$onehot(cause_q);
	endproperty
	a_onehot: assert property (p_onehot) else $error("cause flags not one-hot");

	property p_scratch_keep;
		sw_rst_q && !wr_scratch |=> $stable(scratch_q[0]) && $stable(scratch_q[3]);
	endproperty
	a_scratch_keep: assert property (p_scratch_keep) else $error("scratch lost on reset");

	property p_wdog_vec;
		watchdog_reset && !pin_rst_q ##1 !watchdog_reset && !pin_rst_q |=> use_watchdog_vector;
	endproperty
	a_wdog_vec: assert property (p_wdog_vec) else $error("watchdog vector not chosen");

	property p_wait_block;
		ctrl_q.wait_disable[0] && wait_instr && !sys_rst |=> !wait_entry && irq_stat_q[1];
	endproperty
	a_wait_block: assert property (p_wait_block) else $error("wait not refused");

endmodule // sicr_top

//--- bench/sicr_core_model.sv
// Purpose: processor-side master on the register bus of the integration bank
// Assumes: one write and one read under way at most; registered slave outputs
// Notes:   waits have no limit of their own; only the bench watchdog ends a hang
`timescale 1ns/10ps

module sicr_core_model (
	// clock
	input  wire logic        aclk,
	// write request and response
	output logic [7:0]       s_axil_awaddr,
	output logic             s_axil_awvalid,
	input  wire logic        s_axil_awready,
	output logic [31:0]      s_axil_wdata,
	output logic [3:0]       s_axil_wstrb,
	output logic             s_axil_wvalid,
	input  wire logic        s_axil_wready,
	input  wire logic [1:0]  s_axil_bresp,
	input  wire logic        s_axil_bvalid,
	output logic             s_axil_bready,
	// read request and response
	output logic [7:0]       s_axil_araddr,
	output logic             s_axil_arvalid,
	input  wire logic        s_axil_arready,
	input  wire logic [31:0] s_axil_rdata,
	input  wire logic [1:0]  s_axil_rresp,
	input  wire logic        s_axil_rvalid,
	output logic             s_axil_rready
);
	// idle bus at time zero
	initial
	begin
		{s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
		{s_axil_awaddr, s_axil_araddr, s_axil_wdata, s_axil_wstrb} = '0;
	end

	// one write, both channels offered together; a taken payload is scrambled
	task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		@(posedge aclk);
		s_axil_awaddr <= a;
		s_axil_awvalid <= 1'b1;
		s_axil_wdata <= d;
		s_axil_wstrb <= s;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axil_awvalid && s_axil_awready)
			begin
				s_axil_awvalid <= 1'b0;
				s_axil_awaddr <= ~a;
			end
			if (s_axil_wvalid && s_axil_wready)
			begin
				s_axil_wvalid <= 1'b0;
				s_axil_wdata <= ~d;
			end
		end
		while ((s_axil_awvalid && !s_axil_awready) || (s_axil_wvalid && !s_axil_wready));
		// bvalid seen at the last handshake edge counts as the answer too
		while (!s_axil_bvalid)
			@(posedge aclk);
		resp = s_axil_bresp;
		s_axil_bready <= 1'b0;
	endtask

	// one read; the answer is taken at the edge where rvalid is seen
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		s_axil_araddr <= a;
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axil_arvalid && s_axil_arready)
			begin
				s_axil_arvalid <= 1'b0;
				s_axil_araddr <= ~a;
			end
		end
		while (!s_axil_rvalid);
		d = s_axil_rdata;
		resp = s_axil_rresp;
		s_axil_rready <= 1'b0;
	endtask
endmodule // sicr_core_model

//--- bench/sicr_top_tb.sv
// Purpose: self-checking bench of the integration register bank
// Assumes: aclk 40 MHz; bus master model drives the register bus
// Notes:   random control words, scratch data and byte strobes from a fixed seed
`timescale 1ns/10ps
`include "sicr_consts.svh"

module sicr_top_tb;
	localparam logic [15:0] ID_HI = 16'h5A31; // arbitrary value
	localparam logic [15:0] ID_LO = 16'h7E04; // arbitrary value
	logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, reset_pin_n = 1'b1, watchdog_reset = 1'b0;
	logic stop_mode = 1'b0, stop_instr = 1'b0, wait_instr = 1'b0, core_tap_enabled = 1'b0;
	logic pwm_reload_sync = 1'b0, routed_pin_in = 1'b0;
	logic [7:0] s_axil_awaddr, s_axil_araddr;
	logic [31:0] s_axil_wdata, s_axil_rdata, s_axil_rdata_q, d;
	logic [3:0] s_axil_wstrb, timer_clock_en, s;
	logic [1:0] s_axil_bresp, s_axil_rresp, resp;
	logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
	logic s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
	logic software_reset_req, use_watchdog_vector, stop_entry, wait_entry, debug_clock_en;
	logic serial_clock_en, timer3_input, irq;
	logic [15:0] ctrl, scr [4];
	int errors = 0, checked = 0, n_sw = 0, n_stop = 0, n_wait = 0, s0, w0;

	always #12.5 aclk = ~aclk;

	sicr_top #(.CHIP_ID_UPPER(ID_HI), .CHIP_ID_LOWER(ID_LO)) i_sicr_top (.aclk, .aresetn,
		.por_n, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
		.s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
		.s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
		.s_axil_rvalid, .s_axil_rready, .reset_pin_n, .watchdog_reset, .software_reset_req,
		.use_watchdog_vector, .stop_mode, .stop_instr, .wait_instr, .stop_entry, .wait_entry,
		.core_tap_enabled, .debug_clock_en, .timer_clock_en, .serial_clock_en,
		.pwm_reload_sync, .routed_pin_in, .timer3_input, .irq);

	sicr_core_model i_sicr_core_model (.aclk, .s_axil_awaddr, .s_axil_awvalid,
		.s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
		.s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
		.s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready);

	// count one-cycle pulses so a missed or doubled pulse shows up
	always @(posedge aclk)
	begin
		if (software_reset_req === 1'b1) n_sw <= n_sw + 1;
		if (stop_entry === 1'b1) n_stop <= n_stop + 1;
		if (wait_entry === 1'b1) n_wait <= n_wait + 1;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] v, input logic [3:0] b = 4'h3);
		i_sicr_core_model.write({idx, 2'b00}, v, b, resp);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input string what);
		i_sicr_core_model.read({idx, 2'b00}, s_axil_rdata_q, resp);
		chk({resp, s_axil_rdata_q}, {`SICR_RESP_OKAY, 16'h0000, exp}, what);
	endtask

	task automatic rd_scr;
		for (int i = 0; i < 4; i++)
			rd(6'(`SICR_IDX_SCRATCH0 + i), scr[i], "scratch word");
	endtask

	// one stop and one wait instruction from the core
	task automatic pulse_instr;
		s0 = n_stop;
		w0 = n_wait;
		@(posedge aclk);
		{stop_instr, wait_instr} <= 2'b11;
		@(posedge aclk);
		{stop_instr, wait_instr} <= 2'b00;
		cyc(3);
	endtask

	task automatic src_reset(input logic pin, input logic wd, input logic por);
		@(posedge aclk);
		{reset_pin_n, watchdog_reset, por_n} <= {~pin, wd, ~por};
		cyc(4);
		por_n <= 1'b1;
		cyc(4);
		{reset_pin_n, watchdog_reset} <= 2'b10;
		cyc(4);
	endtask

	// control word after a write: reserved bits and locked fields keep their value
	function automatic logic [15:0] exp_ctrl(input logic [15:0] old, input logic [15:0] v);
		logic [15:0] m;
		m = 16'hFA2F;
		if (old[3]) m[3:2] = 2'b00;
		if (old[1]) m[1:0] = 2'b00;
		return (v & m) | (old & ~m);
	endfunction

	task automatic complete_run;
		$display("counts: checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// cut a hang short well beyond the expected run length
	initial
	begin
		#(25 * 20000);
		errors++;
		$display("unexpected at %0t: run did not finish", $time);
		complete_run;
	end

	initial
	begin
		void'($urandom(57892));
		cyc(8);
		{aresetn, por_n} <= 2'b11;
		cyc(2);
		rd(`SICR_IDX_CTRL, 16'h0000, "control reset");
		rd(`SICR_IDX_CAUSE, 16'h0004, "cause after power-on");
		rd(`SICR_IDX_ID_UPPER, ID_HI, "id upper");
		wr(`SICR_IDX_ID_LOWER, 32'hFFFF_FFFF);
		rd(`SICR_IDX_ID_LOWER, ID_LO, "id lower after write");
		wr(`SICR_IDX_CAUSE, 32'h0000_FFFF);
		rd(`SICR_IDX_CAUSE, 16'h0004, "cause after write");
		wr(6'h08, 32'h0000_1234);
		chk(resp, `SICR_RESP_SLVERR, "unmapped write");
		i_sicr_core_model.read(8'h20, s_axil_rdata_q, resp);
		chk({resp, s_axil_rdata_q}, {`SICR_RESP_SLVERR, 32'h0}, "unmapped read");
		$display("test reset values done");
		// random control words with random mode and pin inputs; bit 4 and locks left clear
		ctrl = 16'h0000;
		for (int i = 0; i < 8; i++)
		begin
			d = $urandom;
			{d[4], d[3], d[1]} = 3'b000;
			wr(`SICR_IDX_CTRL, d);
			ctrl = exp_ctrl(ctrl, d[15:0]);
			{stop_mode, core_tap_enabled, pwm_reload_sync, routed_pin_in} <= 4'($urandom);
			cyc(5);
			chk(timer_clock_en, stop_mode ? ctrl[15:12] : 4'hF, "timer clocks");
			chk(serial_clock_en, !stop_mode | ctrl[11], "serial clock");
			chk(timer3_input, ctrl[9] ? routed_pin_in : pwm_reload_sync, "timer 3 input");
			chk(debug_clock_en, ctrl[5] | core_tap_enabled, "debug clock");
			rd(`SICR_IDX_CTRL, ctrl, "control readback");
		end
		$display("test control fields done");
		// refused stop and wait raise masked events, then entry works again
		wr(`SICR_IDX_IRQ_MASK, 32'h0);
		wr(`SICR_IDX_IRQ_STAT, 32'h7);
		wr(`SICR_IDX_CTRL, 32'h0000_0805); // serial clock kept for lin sleep
		ctrl = exp_ctrl(ctrl, 16'h0805);
		pulse_instr;
		chk(n_stop - s0, 0, "stop entered while disabled");
		chk(n_wait - w0, 0, "wait entered while disabled");
		chk(irq, 1'b0, "irq while masked");
		rd(`SICR_IDX_IRQ_STAT, 16'h0003, "refused events");
		wr(`SICR_IDX_IRQ_MASK, 32'h7);
		cyc(2);
		chk(irq, 1'b1, "irq unmasked");
		wr(`SICR_IDX_IRQ_STAT, 32'h3);
		cyc(2);
		chk(irq, 1'b0, "irq after clear");
		wr(`SICR_IDX_CTRL, 32'h0);
		ctrl = exp_ctrl(ctrl, 16'h0000);
		pulse_instr;
		chk(n_stop - s0, 1, "stop entry");
		chk(n_wait - w0, 1, "wait entry");
		// lock both fields, then try to change them
		wr(`SICR_IDX_CTRL, 32'h0000_000F);
		ctrl = exp_ctrl(ctrl, 16'h000F);
		d = $urandom;
		d[4] = 1'b0;
		wr(`SICR_IDX_CTRL, d);
		ctrl = exp_ctrl(ctrl, d[15:0]);
		rd(`SICR_IDX_CTRL, ctrl, "locked fields");
		pulse_instr;
		chk(n_stop - s0 + n_wait - w0, 0, "entry while locked off");
		rd(`SICR_IDX_IRQ_STAT, 16'h0007, "lock and refusal events");
		wr(`SICR_IDX_IRQ_STAT, 32'h7);
		$display("test stop and wait done");
		// scratch words with random strobes survive a software reset
		scr = '{default: 16'h0000}; // unwritten lanes still hold the power-on zero
		for (int i = 0; i < 4; i++)
		begin
			d = $urandom;
			s = $urandom;
			wr(6'(`SICR_IDX_SCRATCH0 + i), d, s);
			scr[i] = {s[1] ? d[15:8] : scr[i][15:8], s[0] ? d[7:0] : scr[i][7:0]};
		end
		w0 = n_sw;
		wr(`SICR_IDX_CTRL, 32'h0000_0010);
		cyc(3);
		chk(n_sw - w0, 1, "software reset pulse");
		rd(`SICR_IDX_CTRL, 16'h0000, "control after software reset");
		rd(`SICR_IDX_CAUSE, 16'h0020, "software cause");
		rd_scr;
		// watchdog alone, then pin and watchdog together
		wr(`SICR_IDX_CTRL, 32'h0000_000A);
		src_reset(1'b0, 1'b1, 1'b0);
		rd(`SICR_IDX_CTRL, 16'h0000, "locks cleared by reset");
		rd(`SICR_IDX_CAUSE, 16'h0010, "watchdog cause");
		chk(use_watchdog_vector, 1'b1, "watchdog vector");
		src_reset(1'b1, 1'b1, 1'b0);
		rd(`SICR_IDX_CAUSE, 16'h0008, "pin over watchdog");
		chk(use_watchdog_vector, 1'b0, "normal vector");
		rd_scr;
		// power-on with the pin still low after release, then a plain power-on
		src_reset(1'b1, 1'b0, 1'b1);
		rd(`SICR_IDX_CAUSE, 16'h0008, "pin held past power-on");
		src_reset(1'b0, 1'b0, 1'b1);
		rd(`SICR_IDX_CAUSE, 16'h0004, "power-on cause");
		scr = '{default: 16'h0000};
		rd_scr;
		$display("test reset causes done");
		complete_run;
	end
endmodule // sicr_top_tb
